/* File: core/etfe_pkg.sv */
// Purpose: Shared constants and types of the Ethernet test frame engine.
// Assumes: One clock, sys_clk, for the processor side and the MAC client side.
// Notes: Byte streams carry data with an end-of-frame flag; words carry eight bytes, byte 0 in bits 7:0.
package etfe_pkg;
  localparam int STORE_BYTES = 16384;
  localparam int STORE_AW = 14;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] ADDR_BYTES = 4'h6;
  localparam logic [3:0] HDR_LAST = 4'hb;
  localparam logic [2:0] WORD_LAST = 3'h7;
  localparam logic [7:0] PAT_SEED = 8'h00;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } etfe_byte_t;

  typedef struct packed {
    logic [63:0] data;
    logic [2:0] tail;
    logic last;
  } etfe_word_t;

  typedef enum logic [1:0] {SRC_NONE, SRC_LOOP, SRC_GEN, SRC_CPU} etfe_src_t;
  typedef enum logic [1:0] {SW_FILL, SW_HDR, SW_PASS} etfe_swap_t;
endpackage : etfe_pkg

/* File: core/etfe_top.sv */
// Purpose: Test frame peripheral between the processor and the MAC client FIFOs.
// Assumes: The MAC client logic and the processor logic run on sys_clk.
// Notes: Transmit ownership is decided per frame, so sources never interleave bytes.
`timescale 1ns/1ps

module etfe_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_q <= pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : etfe_fifo

module etfe_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cfg_loopback,
  input wire logic cfg_swap,
  input wire logic gen_use_store,
  input wire logic gen_continuous,
  input wire logic gen_start,
  input wire logic [etfe_pkg::STORE_AW-1:0] gen_len,
  output logic gen_busy,
  input wire logic store_wr_en,
  input wire logic [etfe_pkg::STORE_AW-1:0] store_wr_addr,
  input wire logic [7:0] store_wr_data,
  input wire logic cpu_tx_valid,
  output logic cpu_tx_ready,
  input wire etfe_pkg::etfe_word_t cpu_tx_word,
  output logic cpu_rx_valid,
  input wire logic cpu_rx_ready,
  output etfe_pkg::etfe_byte_t cpu_rx_byte,
  output logic mac_tx_valid,
  input wire logic mac_tx_ready,
  output etfe_pkg::etfe_byte_t mac_tx_byte,
  input wire logic mac_rx_valid,
  output logic mac_rx_ready,
  input wire etfe_pkg::etfe_byte_t mac_rx_byte
);
  logic [7:0] store_q [etfe_pkg::STORE_BYTES];
  etfe_pkg::etfe_word_t word_q;
  logic word_valid_q;
  logic [2:0] word_idx_q;
  logic gen_busy_q;
  logic [etfe_pkg::STORE_AW-1:0] gen_cnt_q;
  logic [etfe_pkg::STORE_AW-1:0] gen_len_q;
  etfe_pkg::etfe_src_t owner_q;
  etfe_pkg::etfe_swap_t sw_q;
  logic [7:0] hdr_q [12];
  logic [3:0] sw_cnt_q;
  logic [3:0] sw_n_q;
  logic sw_hlast_q;
  logic rd_valid_q;
  etfe_pkg::etfe_byte_t rd_byte_q;

  etfe_pkg::etfe_byte_t conv_byte;
  etfe_pkg::etfe_byte_t gen_byte;
  etfe_pkg::etfe_byte_t lb_out;
  etfe_pkg::etfe_byte_t txf_in;
  etfe_pkg::etfe_byte_t rxo;
  etfe_pkg::etfe_src_t pick;
  etfe_pkg::etfe_src_t sel;
  logic txf_in_valid;
  logic txf_in_ready;
  logic tx_fire;
  logic conv_fire;
  logic gen_fire;
  logic lb_out_valid;
  logic lb_out_ready;
  logic lb_in_ready;
  logic lb_in_fire;
  logic rxo_valid;
  logic rxo_ready;
  logic rd_ready;
  logic rd_load;
  logic sw_full;
  logic [3:0] sw_src;

  etfe_fifo #(.W($bits(etfe_pkg::etfe_byte_t)), .DEPTH(etfe_pkg::FIFO_DEPTH)) u_txf (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .in_valid(txf_in_valid), .in_ready(txf_in_ready), .in_data(txf_in),
    .out_valid(mac_tx_valid), .out_ready(mac_tx_ready), .out_data(mac_tx_byte)
  );
  etfe_fifo #(.W($bits(etfe_pkg::etfe_byte_t)), .DEPTH(etfe_pkg::FIFO_DEPTH)) u_rxf (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .in_valid(mac_rx_valid), .in_ready(mac_rx_ready), .in_data(mac_rx_byte),
    .out_valid(rxo_valid), .out_ready(rxo_ready), .out_data(rxo)
  );

  always_ff @(posedge sys_clk)
  begin
    if (store_wr_en)
      store_q[store_wr_addr] <= store_wr_data;
  end

  assign cpu_tx_ready = !word_valid_q;
  assign conv_byte.data = word_q.data[{word_idx_q, 3'h0} +: 8];
  assign conv_byte.last = word_q.last && (word_idx_q == word_q.tail);
  assign conv_fire = (sel == etfe_pkg::SRC_CPU) && word_valid_q && txf_in_ready;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_q <= '0;
      word_valid_q <= 1'b0;
      word_idx_q <= '0;
    end
    else if (cpu_tx_valid && cpu_tx_ready)
    begin
      word_q <= cpu_tx_word;
      word_valid_q <= 1'b1;
      word_idx_q <= '0;
    end
    else if (conv_fire)
    begin
      word_valid_q <= !(conv_byte.last || word_idx_q == etfe_pkg::WORD_LAST);
      word_idx_q <= word_idx_q + 3'h1;
    end
  end

  assign gen_busy = gen_busy_q;
  assign gen_byte.data = gen_use_store ? store_q[gen_cnt_q] : etfe_pkg::PAT_SEED + gen_cnt_q[7:0];
  assign gen_byte.last = (gen_cnt_q == gen_len_q);
  assign gen_fire = (sel == etfe_pkg::SRC_GEN) && gen_busy_q && txf_in_ready;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gen_busy_q <= 1'b0;
      gen_cnt_q <= '0;
      gen_len_q <= '0;
    end
    else if (!gen_busy_q && (gen_start || gen_continuous))
    begin
      gen_busy_q <= 1'b1;
      gen_cnt_q <= '0;
      gen_len_q <= gen_len;
    end
    else if (gen_fire)
    begin
      gen_busy_q <= !gen_byte.last;
      gen_cnt_q <= gen_cnt_q + 1'b1;
    end
  end

  assign pick = (cfg_loopback && lb_out_valid) ? etfe_pkg::SRC_LOOP :
                gen_busy_q ? etfe_pkg::SRC_GEN :
                word_valid_q ? etfe_pkg::SRC_CPU : etfe_pkg::SRC_NONE;
  assign sel = (owner_q != etfe_pkg::SRC_NONE) ? owner_q : pick;
  assign txf_in_valid = ((sel == etfe_pkg::SRC_LOOP) && lb_out_valid) || ((sel == etfe_pkg::SRC_GEN) && gen_busy_q)
                        || ((sel == etfe_pkg::SRC_CPU) && word_valid_q);
  assign txf_in = (sel == etfe_pkg::SRC_LOOP) ? lb_out : (sel == etfe_pkg::SRC_GEN) ? gen_byte : conv_byte;
  assign tx_fire = txf_in_valid && txf_in_ready;
  assign lb_out_ready = (sel == etfe_pkg::SRC_LOOP) && txf_in_ready;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      owner_q <= etfe_pkg::SRC_NONE;
    else
      owner_q <= (tx_fire && txf_in.last) ? etfe_pkg::SRC_NONE : sel;
  end

  assign sw_full = (sw_n_q == etfe_pkg::HDR_LAST);
  assign sw_src = !sw_full ? sw_cnt_q : (sw_cnt_q < etfe_pkg::ADDR_BYTES) ? sw_cnt_q + etfe_pkg::ADDR_BYTES
                  : sw_cnt_q - etfe_pkg::ADDR_BYTES;
  assign lb_out_valid = (sw_q == etfe_pkg::SW_HDR) || (rxo_valid && cfg_loopback &&
                        (sw_q == etfe_pkg::SW_PASS || (sw_q == etfe_pkg::SW_FILL && !cfg_swap)));
  assign lb_out.data = (sw_q == etfe_pkg::SW_HDR) ? hdr_q[sw_src] : rxo.data;
  assign lb_out.last = (sw_q == etfe_pkg::SW_HDR) ? (sw_hlast_q && sw_cnt_q == sw_n_q) : rxo.last;
  assign lb_in_ready = (sw_q == etfe_pkg::SW_FILL && cfg_swap) ||
                       (sw_q != etfe_pkg::SW_HDR && lb_out_ready);
  assign lb_in_fire = cfg_loopback && rxo_valid && lb_in_ready;

  always_ff @(posedge sys_clk)
  begin
    if (lb_in_fire && sw_q == etfe_pkg::SW_FILL && cfg_swap)
      hdr_q[sw_cnt_q] <= rxo.data;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sw_q <= etfe_pkg::SW_FILL;
      sw_cnt_q <= '0;
      sw_n_q <= '0;
      sw_hlast_q <= 1'b0;
    end
    else
    begin
      unique case (sw_q)
        etfe_pkg::SW_FILL:
        begin
          if (lb_in_fire && cfg_swap)
          begin
            sw_cnt_q <= (rxo.last || sw_cnt_q == etfe_pkg::HDR_LAST) ? '0 : sw_cnt_q + 4'h1;
            sw_n_q <= sw_cnt_q;
            sw_hlast_q <= rxo.last;
            if (rxo.last || sw_cnt_q == etfe_pkg::HDR_LAST)
              sw_q <= etfe_pkg::SW_HDR;
          end
        end
        etfe_pkg::SW_HDR:
        begin
          if (lb_out_ready)
          begin
            sw_cnt_q <= (sw_cnt_q == sw_n_q) ? '0 : sw_cnt_q + 4'h1;
            if (sw_cnt_q == sw_n_q)
              sw_q <= sw_hlast_q ? etfe_pkg::SW_FILL : etfe_pkg::SW_PASS;
          end
        end
        etfe_pkg::SW_PASS:
        begin
          if (lb_in_fire && rxo.last)
            sw_q <= etfe_pkg::SW_FILL;
        end
      endcase
    end
  end

  assign rd_ready = !rd_valid_q || cpu_rx_ready;
  assign rd_load = !cfg_loopback && rxo_valid && rd_ready;
  assign rxo_ready = cfg_loopback ? lb_in_ready : rd_ready;
  assign cpu_rx_valid = rd_valid_q;
  assign cpu_rx_byte = rd_byte_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_valid_q <= 1'b0;
      rd_byte_q <= '0;
    end
    else if (rd_ready)
    begin
      rd_valid_q <= rd_load;
      rd_byte_q <= rd_load ? rxo : rd_byte_q;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  AST_STORE_WR: assert property (store_wr_en |=> store_q[$past(store_wr_addr)] == $past(store_wr_data))
    else $error("Frame store write lost.");
  AST_GEN_START: assert property (gen_start && !gen_busy_q |=> gen_busy_q && gen_cnt_q == '0)
    else $error("Generator did not start.");
  AST_GEN_CONT: assert property (gen_fire && gen_byte.last ##1 gen_continuous |=> gen_busy_q)
    else $error("Continuous mode did not restart.");
  AST_CPU_WORD: assert property (cpu_tx_valid && cpu_tx_ready |=> word_valid_q && word_idx_q == '0)
    else $error("Processor word not taken.");
  AST_CONV_STEP: assert property (conv_fire && !conv_byte.last |=> word_idx_q == $past(word_idx_q) + 3'h1)
    else $error("Word splitter skipped a byte.");
  AST_LOOP_ROUTE: assert property (cfg_loopback && rxo_valid && rxo_ready && (sw_q == etfe_pkg::SW_PASS || !cfg_swap)
                                   |-> tx_fire && txf_in == rxo && !rd_load)
    else $error("Looped frame reached the reader.");
  AST_SWAP_HDR: assert property ($rose(sw_q == etfe_pkg::SW_HDR) && sw_full |-> (sw_q == etfe_pkg::SW_HDR) [*8])
    else $error("Swapped header emitted too early.");
  AST_SWAP_ORDER: assert property (sw_q == etfe_pkg::SW_HDR && sw_full && sw_cnt_q == '0
                                   |-> lb_out.data == hdr_q[etfe_pkg::ADDR_BYTES])
    else $error("Destination not replaced by source.");
  AST_RD_HOLD: assert property (cpu_rx_valid && !cpu_rx_ready |=> cpu_rx_valid && $stable(cpu_rx_byte))
    else $error("Captured byte dropped.");
  AST_MAC_TX: assert property (mac_tx_valid && !mac_tx_ready |=> mac_tx_valid && $stable(mac_tx_byte))
    else $error("Transmit byte withdrawn.");

  COV_GEN_TWO: cover property (gen_fire && gen_byte.last ##[1:20] gen_fire && gen_byte.last);
  COV_SWAP: cover property (sw_q == etfe_pkg::SW_HDR && sw_full ##[1:40] sw_q == etfe_pkg::SW_PASS);
  COV_CPU_FRAME: cover property (conv_fire && conv_byte.last);
endmodule : etfe_top

/* File: tb/etfe_mac_model.sv */
// Purpose: Behavioural MAC client seen from the engine: byte sink on transmit, byte source on receive.
// Assumes: Both directions run on sys_clk with valid/ready transfers.
// Notes: With slow high the sink stalls every other cycle.
`timescale 1ns/1ps
module etfe_mac_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic mac_tx_valid,
  output logic mac_tx_ready,
  input wire etfe_pkg::etfe_byte_t mac_tx_byte,
  output logic mac_rx_valid,
  input wire logic mac_rx_ready,
  output etfe_pkg::etfe_byte_t mac_rx_byte
);
  logic [8:0] txq[$];
  logic ph_q = 1'b0;
  initial mac_rx_valid = 1'b0;
  initial mac_rx_byte = '0;
  assign mac_tx_ready = !slow || ph_q;
  always @(posedge sys_clk)
  begin
    ph_q <= ~ph_q;
    if (rst_b && mac_tx_valid && mac_tx_ready)
      txq.push_back(mac_tx_byte);
  end
  // Released lines show the inverse so stale data is never mistaken for a byte.
  task automatic send_frame(input int n, input logic [7:0] base);
    mac_rx_valid <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      mac_rx_byte <= {base + 8'(i), i == n - 1};
      do @(posedge sys_clk); while (!mac_rx_ready);
    end
    mac_rx_valid <= 1'b0;
    mac_rx_byte <= ~mac_rx_byte;
  endtask : send_frame
endmodule : etfe_mac_model

/* File: tb/ethernet_test_frame_engine_test.sv */
// Purpose: Self-checking bench of the test frame engine.
// Assumes: The MAC model stands on the client FIFOs.
// Notes: Generator rows run in a loop; processor words, loopback, reader and continuous mode follow.
`timescale 1ns/1ps
module ethernet_test_frame_engine_test;
  typedef struct packed {logic us; logic sl; logic [13:0] len; logic [7:0] first;} etfe_row_t;
  localparam etfe_row_t ROWS [4] = '{'{1'b0, 1'b0, 14'h0, etfe_pkg::PAT_SEED},
    '{1'b0, 1'b1, 14'h3, etfe_pkg::PAT_SEED},
    '{1'b1, 1'b0, 14'h7, 8'ha0}, '{1'b0, 1'b1, 14'h14, etfe_pkg::PAT_SEED}};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_loopback = 1'b0;
  logic cfg_swap = 1'b0;
  logic gen_use_store = 1'b0;
  logic gen_continuous = 1'b0;
  logic gen_start = 1'b0;
  logic [13:0] gen_len = '0;
  logic gen_busy, cpu_tx_ready, cpu_rx_valid, mac_tx_valid, mac_rx_ready, mac_tx_ready, mac_rx_valid;
  logic store_wr_en = 1'b0;
  logic [13:0] store_wr_addr = '0;
  logic [7:0] store_wr_data = '0;
  logic cpu_tx_valid = 1'b0;
  logic cpu_rx_ready = 1'b0;
  logic slow = 1'b0;
  logic full_seen;
  etfe_pkg::etfe_word_t cpu_tx_word = '0;
  etfe_pkg::etfe_byte_t cpu_rx_byte, mac_tx_byte, mac_rx_byte;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rx_n = 0;
  logic [8:0] exq[$];

  etfe_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_loopback(cfg_loopback), .cfg_swap(cfg_swap),
    .gen_use_store(gen_use_store), .gen_continuous(gen_continuous), .gen_start(gen_start), .gen_len(gen_len),
    .gen_busy(gen_busy), .store_wr_en(store_wr_en), .store_wr_addr(store_wr_addr),
    .store_wr_data(store_wr_data), .cpu_tx_valid(cpu_tx_valid), .cpu_tx_ready(cpu_tx_ready),
    .cpu_tx_word(cpu_tx_word), .cpu_rx_valid(cpu_rx_valid), .cpu_rx_ready(cpu_rx_ready),
    .cpu_rx_byte(cpu_rx_byte), .mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready),
    .mac_tx_byte(mac_tx_byte), .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready),
    .mac_rx_byte(mac_rx_byte));
  etfe_mac_model mac (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow), .mac_tx_valid(mac_tx_valid),
    .mac_tx_ready(mac_tx_ready), .mac_tx_byte(mac_tx_byte), .mac_rx_valid(mac_rx_valid),
    .mac_rx_ready(mac_rx_ready), .mac_rx_byte(mac_rx_byte));

  always #2.5 sys_clk = ~sys_clk;

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Waits a bounded time for the expected byte count, then compares in order.
  task automatic cmp_tx();
    for (int i = 0; i < 3000 && mac.txq.size() < exq.size(); i++)
      @(posedge sys_clk);
    chk("tx_count", 9'(exq.size()), 9'(mac.txq.size()));
    for (int i = 0; i < exq.size() && i < mac.txq.size(); i++)
      chk("tx_byte", exq[i], mac.txq[i]);
    exq.delete();
    mac.txq.delete();
  endtask : cmp_tx

  initial
  begin
    repeat (10) @(posedge sys_clk);
    chk("reset_outs", 9'h09, {4'h0, gen_busy, cpu_tx_ready, cpu_rx_valid, mac_tx_valid, mac_rx_ready});
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      store_wr_en <= 1'b1;
      store_wr_addr <= 14'(i);
      store_wr_data <= 8'ha0 + 8'(i);
      @(posedge sys_clk);
    end
    store_wr_en <= 1'b0;
    foreach (ROWS[r])
    begin
      slow <= ROWS[r].sl;
      gen_use_store <= ROWS[r].us;
      gen_len <= ROWS[r].len;
      gen_start <= 1'b1;
      @(posedge sys_clk);
      gen_start <= 1'b0;
      #1 chk("gen_busy", 9'h1, {8'h0, gen_busy});
      for (int k = 0; k <= ROWS[r].len; k++)
        exq.push_back({ROWS[r].first + 8'(k), k == ROWS[r].len});
      cmp_tx();
    end
    cpu_tx_valid <= 1'b1;
    cpu_tx_word <= {64'h0706050403020100, 3'h0, 1'b0};
    do @(posedge sys_clk); while (!cpu_tx_ready);
    cpu_tx_word <= {64'h0f0e0d0c0b0a0908, 3'h2, 1'b1};
    do @(posedge sys_clk); while (!cpu_tx_ready);
    cpu_tx_valid <= 1'b0;
    for (int k = 0; k < 11; k++)
      exq.push_back({8'(k), k == 10});
    cmp_tx();
    cfg_loopback <= 1'b1;
    cfg_swap <= 1'b1;
    mac.send_frame(14, 8'h40);
    for (int k = 0; k < 14; k++)
      exq.push_back({8'h40 + 8'(k < 6 ? k + 6 : k < 12 ? k - 6 : k), k == 13});
    cmp_tx();
    cfg_swap <= 1'b0;
    mac.send_frame(13, 8'h60);
    for (int k = 0; k < 13; k++)
      exq.push_back({8'h60 + 8'(k), k == 12});
    cmp_tx();
    cfg_loopback <= 1'b0;
    full_seen = 1'b0;
    fork
      mac.send_frame(12, 8'h80);
    join_none
    for (int i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      full_seen |= !mac_rx_ready;
    end
    chk("rx_full", 9'h1, {8'h0, full_seen});
    cpu_rx_ready <= 1'b1;
    for (int i = 0; rx_n < 12 && i < 100; i++)
    begin
      @(posedge sys_clk);
      if (cpu_rx_valid === 1'b1)
      begin
        chk("rx_byte", {8'h80 + 8'(rx_n), rx_n == 11}, cpu_rx_byte);
        rx_n++;
      end
    end
    chk("rx_count", 9'h00c, 9'(rx_n));
    gen_use_store <= 1'b0;
    gen_len <= 14'h1;
    gen_continuous <= 1'b1;
    gen_start <= 1'b1;
    @(posedge sys_clk);
    gen_start <= 1'b0;
    for (int i = 0; i < 200 && mac.txq.size() < 6; i++)
      @(posedge sys_clk);
    gen_continuous <= 1'b0;
    for (int i = 0; i < 200 && gen_busy !== 1'b0; i++)
      @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    for (int k = 0; k < 6; k++)
      exq.push_back({etfe_pkg::PAT_SEED + 8'(k % 2), k % 2 == 1});
    mac.txq = mac.txq[0:5];
    cmp_tx();
    // A reset right after a generator start, before any byte goes out, must drop the frame and leave every handshake idle.
    gen_len <= 14'h14;
    gen_start <= 1'b1;
    @(posedge sys_clk);
    gen_start <= 1'b0;
    rst_b <= 1'b0;
    @(posedge sys_clk);
    #1 chk("reset_mid", 9'h09, {4'h0, gen_busy, cpu_tx_ready, cpu_rx_valid, mac_tx_valid, mac_rx_ready});
    @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("reset_drop", 9'h000, 9'(mac.txq.size()));
    finish_test();
  end
endmodule : ethernet_test_frame_engine_test
